// ### hdl/sscs_pkg.sv
// Constants for the slow-channel message scheduler
package sscs_pkg;
    localparam logic [7:0] SSCS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SSCS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SSCS_ADDR_MASK = 8'h08;
    localparam logic [7:0] SSCS_ADDR_SLOT = 8'h0c;
    localparam logic [7:0] SSCS_ADDR_PAGES = 8'h10;
    localparam logic [7:0] SSCS_ADDR_REV = 8'h14;
    localparam logic [7:0] SSCS_ADDR_STYPE = 8'h18;
    localparam logic [7:0] SSCS_ADDR_IDENT = 8'h1c;
    localparam logic [7:0] SSCS_ADDR_MFR = 8'h20;
    localparam logic [7:0] SSCS_ADDR_EXC = 8'h24;
    localparam logic [7:0] SSCS_ADDR_USER = 8'h40;
    localparam int SSCS_USER_N = 16;
    localparam logic [4:0] SSCS_SLOT_FIRST = 5'h01;
    localparam logic [4:0] SSCS_SLOT_LAST = 5'h1f;
    localparam logic [4:0] SSCS_SLOT_STYPE = 5'h06;
    localparam logic [4:0] SSCS_SLOT_MFR = 5'h0a;
    localparam logic [4:0] SSCS_SLOT_REV = 5'h0e;
    localparam logic [4:0] SSCS_SLOT_TEMP = 5'h12;
    localparam logic [4:0] SSCS_SLOT_EXC = 5'h16;
    localparam logic [4:0] SSCS_SLOT_VREC = 5'h1a;
    localparam logic [4:0] SSCS_SLOT_IDENT = 5'h1e;
    localparam logic [7:0] SSCS_ID_FAULT = 8'h01;
    localparam logic [7:0] SSCS_ID_STYPE = 8'h03;
    localparam logic [7:0] SSCS_ID_MFR = 8'h05;
    localparam logic [7:0] SSCS_ID_REV = 8'h06;
    localparam logic [7:0] SSCS_ID_TEMP = 8'h23;
    localparam logic [7:0] SSCS_ID_EXC = 8'h83;
    localparam logic [7:0] SSCS_ID_VREC = 8'h85;
    localparam logic [7:0] SSCS_ID_IDENT = 8'h87;
    localparam int SSCS_CTRL_EN_BIT = 0;
    localparam int SSCS_ST_WRAP_BIT = 0;
    localparam int SSCS_ST_FAULT_BIT = 1;
    localparam int SSCS_ST_W = 2;
    localparam logic [11:0] SSCS_RST_WORD = 12'h000;
    // Arbitrary neutral value, not a real maker code
    localparam logic [11:0] SSCS_RST_MFR = 12'h000;
    localparam logic [15:0] SSCS_RST_PAGES = 16'h4321;
    localparam logic [7:0] SSCS_RST_EXC = 8'h00;

    typedef enum logic {sscs_idle, sscs_hold} sscs_state_t;
endpackage

// ### hdl/sscs_sched.sv
// Slow-channel message scheduler with APB register file
`timescale 1ns/1ps
`default_nettype none
module sscs_sched
    import sscs_pkg::*;
(
    input wire logic clock_in, // 200 MHz clock
    input wire logic sys_rst_in, // Sync reset, active high
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error on unmapped address
    input wire logic [8:0] fault_flags_in, // Live fault bits
    input wire logic [11:0] temperature_in, // On-chip temperature
    input wire logic [16:0] receiver_coil_voltage_in, // Coil amplitude
    output logic msg_valid_out, // Message ready for the framer
    input wire logic msg_ready_in, // Framer takes message
    output logic [4:0] msg_slot_out, // Slot of the message
    output logic [7:0] msg_id_out, // Message ID
    output logic [11:0] msg_data_out, // Message data word
    output logic irq_out // Level interrupt
);
    typedef struct packed {
        sscs_state_t state;
        logic [4:0] slot;
        logic [4:0] mslot;
        logic [7:0] mid;
        logic [11:0] mdata;
        logic enable;
        logic [SSCS_ST_W-1:0] status;
        logic [SSCS_ST_W-1:0] mask;
        logic [15:0] pages;
        logic [11:0] rev;
        logic [11:0] stype;
        logic [11:0] ident;
        logic [11:0] mfr;
        logic [7:0] exc;
        logic [SSCS_USER_N-1:0][15:0] user;
        logic [31:0] rdata;
    } sscs_regs_t;

    sscs_regs_t r;
    sscs_regs_t next_r;

    // Index of a user data slot, or -1 for fixed slots
    function automatic int sscs_user_idx(input logic [4:0] s);
        case (s)
            5'h02: return 0;
            5'h03: return 1;
            5'h04: return 2;
            5'h07: return 3;
            5'h08: return 4;
            5'h0b: return 5;
            5'h0c: return 6;
            5'h0f: return 7;
            5'h10: return 8;
            5'h13: return 9;
            5'h14: return 10;
            5'h17: return 11;
            5'h18: return 12;
            5'h1b: return 13;
            5'h1c: return 14;
            5'h1f: return 15;
            default: return -1;
        endcase
    endfunction

    logic setup;
    logic access;
    logic hit;
    logic [3:0] uidx;
    logic user_hit;
    logic [3:0] page;
    logic [1:0] grp;
    logic [7:0] cid;
    logic [11:0] cdata;
    logic [SSCS_ST_W-1:0] st_set;
    logic [SSCS_ST_W-1:0] st_clr;
    logic [31:0] rval;
    int ui;

    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in;
    assign uidx = paddr_in[5:2];
    assign user_hit = (paddr_in[7:6] == SSCS_ADDR_USER[7:6]) && (paddr_in[1:0] == 2'h0);

    always_comb begin
        hit = 1'b1;
        rval = 32'h0;
        if (user_hit) begin
            rval = {16'h0, r.user[uidx]};
        end else if (paddr_in == SSCS_ADDR_CTRL) begin
            rval = {31'h0, r.enable};
        end else if (paddr_in == SSCS_ADDR_STATUS) begin
            rval = {30'h0, r.status};
        end else if (paddr_in == SSCS_ADDR_MASK) begin
            rval = {30'h0, r.mask};
        end else if (paddr_in == SSCS_ADDR_SLOT) begin
            rval = {27'h0, r.slot};
        end else if (paddr_in == SSCS_ADDR_PAGES) begin
            rval = {16'h0, r.pages};
        end else if (paddr_in == SSCS_ADDR_REV) begin
            rval = {20'h0, r.rev};
        end else if (paddr_in == SSCS_ADDR_STYPE) begin
            rval = {20'h0, r.stype};
        end else if (paddr_in == SSCS_ADDR_IDENT) begin
            rval = {20'h0, r.ident};
        end else if (paddr_in == SSCS_ADDR_MFR) begin
            rval = {20'h0, r.mfr};
        end else if (paddr_in == SSCS_ADDR_EXC) begin
            rval = {24'h0, r.exc};
        end else begin
            hit = 1'b0;
        end
    end

    // Content of the slot that is loaded next
    always_comb begin
        ui = sscs_user_idx(r.slot);
        if (r.slot < 5'h0a) begin
            grp = 2'd0;
        end else if (r.slot < 5'h12) begin
            grp = 2'd1;
        end else if (r.slot < 5'h1a) begin
            grp = 2'd2;
        end else begin
            grp = 2'd3;
        end
        page = r.pages[grp*4 +: 4];
        cid = SSCS_ID_FAULT;
        cdata = 12'h000;
        if (r.slot[1:0] == 2'b01) begin
            cid = SSCS_ID_FAULT;
            cdata = {3'h0, fault_flags_in};
        end else if (ui >= 0) begin
            // page and item form the ID
            cid = {page, r.user[ui[3:0]][15:12]};
            cdata = r.user[ui[3:0]][11:0];
        end else if (r.slot == SSCS_SLOT_STYPE) begin
            cid = SSCS_ID_STYPE;
            cdata = r.stype;
        end else if (r.slot == SSCS_SLOT_MFR) begin
            cid = SSCS_ID_MFR;
            cdata = r.mfr;
        end else if (r.slot == SSCS_SLOT_REV) begin
            cid = SSCS_ID_REV;
            cdata = r.rev;
        end else if (r.slot == SSCS_SLOT_TEMP) begin
            cid = SSCS_ID_TEMP;
            cdata = temperature_in;
        end else if (r.slot == SSCS_SLOT_EXC) begin
            cid = SSCS_ID_EXC;
            cdata = {4'h0, r.exc};
        end else if (r.slot == SSCS_SLOT_VREC) begin
            cid = SSCS_ID_VREC;
            cdata = receiver_coil_voltage_in[16:5];
        end else if (r.slot == SSCS_SLOT_IDENT) begin
            cid = SSCS_ID_IDENT;
            cdata = r.ident;
        end
    end

    always_comb begin
        next_r = r;
        st_set = '0;
        st_clr = '0;
        if (setup) begin
            next_r.rdata = pwrite_in ? 32'h0 : rval;
        end
        if (access && hit && pwrite_in) begin
            if (user_hit) begin
                next_r.user[uidx] = pwdata_in[15:0];
            end else if (paddr_in == SSCS_ADDR_CTRL) begin
                next_r.enable = pwdata_in[SSCS_CTRL_EN_BIT];
            end else if (paddr_in == SSCS_ADDR_MASK) begin
                next_r.mask = pwdata_in[SSCS_ST_W-1:0];
            end else if (paddr_in == SSCS_ADDR_PAGES) begin
                next_r.pages = pwdata_in[15:0];
            end else if (paddr_in == SSCS_ADDR_REV) begin
                next_r.rev = pwdata_in[11:0];
            end else if (paddr_in == SSCS_ADDR_STYPE) begin
                next_r.stype = pwdata_in[11:0];
            end else if (paddr_in == SSCS_ADDR_IDENT) begin
                next_r.ident = pwdata_in[11:0];
            end else if (paddr_in == SSCS_ADDR_MFR) begin
                next_r.mfr = pwdata_in[11:0];
            end else if (paddr_in == SSCS_ADDR_EXC) begin
                next_r.exc = pwdata_in[7:0];
            end
        end
        // Clear only bits that the read returned
        if (access && !pwrite_in && paddr_in == SSCS_ADDR_STATUS) begin
            st_clr = r.rdata[SSCS_ST_W-1:0];
        end
        case (r.state)
            sscs_idle: begin
                if (r.enable) begin
                    next_r.state = sscs_hold;
                    next_r.mslot = r.slot;
                    next_r.mid = cid;
                    next_r.mdata = cdata;
                end
            end
            sscs_hold: begin
                if (msg_ready_in) begin
                    next_r.state = sscs_idle;
                    if (r.slot == SSCS_SLOT_LAST) begin
                        next_r.slot = SSCS_SLOT_FIRST;
                        st_set[SSCS_ST_WRAP_BIT] = 1'b1;
                    end else begin
                        next_r.slot = 5'(r.slot + 5'h01);
                    end
                    // Judged by slot: a user slot may form the same ID as the fault message
                    if (r.mslot[1:0] == 2'b01 && r.mdata[8:0] != 9'h000) begin
                        st_set[SSCS_ST_FAULT_BIT] = 1'b1;
                    end
                end
            end
            default: next_r.state = sscs_idle;
        endcase
        // Set wins over a clear in the same cycle
        next_r.status = (r.status & ~st_clr) | st_set;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            r.state <= sscs_idle;
            r.slot <= SSCS_SLOT_FIRST;
            r.mslot <= SSCS_SLOT_FIRST;
            r.mid <= 8'h00;
            r.mdata <= SSCS_RST_WORD;
            r.enable <= 1'b0;
            r.status <= '0;
            r.mask <= '0;
            r.pages <= SSCS_RST_PAGES;
            r.rev <= SSCS_RST_WORD;
            r.stype <= SSCS_RST_WORD;
            r.ident <= SSCS_RST_WORD;
            r.mfr <= SSCS_RST_MFR;
            r.exc <= SSCS_RST_EXC;
            r.user <= '0;
            r.rdata <= 32'h0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata_out = r.rdata;
    assign pready_out = access;
    assign pslverr_out = access && !hit;
    assign msg_valid_out = (r.state == sscs_hold);
    assign msg_slot_out = r.mslot;
    assign msg_id_out = r.mid;
    assign msg_data_out = r.mdata;
    assign irq_out = |(r.status & r.mask);
endmodule
`default_nettype wire

// ### testbench/sscs_checker.sv
// Port assertions for the slow-channel scheduler
`timescale 1ns/1ps
`default_nettype none
module sscs_checker
    import sscs_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic msg_valid_out,
    input wire logic msg_ready_in,
    input wire logic [4:0] msg_slot_out,
    input wire logic [7:0] msg_id_out,
    input wire logic [11:0] msg_data_out,
    input wire logic [8:0] fault_flags_in,
    input wire logic [11:0] temperature_in,
    input wire logic [16:0] receiver_coil_voltage_in
);
    wire logic v = msg_valid_out;
    wire logic tk = msg_valid_out && msg_ready_in;
    wire logic [4:0] s = msg_slot_out;
    wire logic [11:0] d = msg_data_out;
    wire logic [11:0] amp = receiver_coil_voltage_in[16:5];
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    AST_HOLD: assert property (v && !msg_ready_in |=> v && $stable({s, msg_id_out, d}))
        else $error("offered message changed before it was taken");
    AST_GAP: assert property (tk |=> !v)
        else $error("valid did not drop after a take");
    AST_ORDER: assert property (tk ##1 !v ##1 v |->
        s == ($past(s, 2) == 5'h1f ? 5'h01 : $past(s, 2) + 5'h01))
        else $error("slot order broken");
    AST_FAULT: assert property ($rose(v) && s[1:0] == 2'b01 |->
        msg_id_out == 8'h01 && d == {3'h0, $past(fault_flags_in)})
        else $error("fault message wrong");
    AST_REV: assert property (v && s == 5'h0e |-> msg_id_out == 8'h06)
        else $error("revision message wrong");
    AST_TEMP: assert property ($rose(v) && s == 5'h12 |->
        msg_id_out == 8'h23 && d == $past(temperature_in))
        else $error("temperature message wrong");
    AST_EXC: assert property (v && s == 5'h16 |-> msg_id_out == 8'h83 && d[11:8] == 4'h0)
        else $error("excitation message wrong");
    AST_VREC: assert property ($rose(v) && s == 5'h1a |->
        msg_id_out == 8'h85 && d == $past(amp))
        else $error("amplitude message wrong");
    cover property (tk && s == 5'h1f);
    cover property (v && !msg_ready_in);
    cover property ($rose(v) && s == 5'h1a);
endmodule
bind sscs_sched sscs_checker i_sscs_checker (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .msg_valid_out(msg_valid_out),
    .msg_ready_in(msg_ready_in), .msg_slot_out(msg_slot_out), .msg_id_out(msg_id_out),
    .msg_data_out(msg_data_out), .fault_flags_in(fault_flags_in),
    .temperature_in(temperature_in), .receiver_coil_voltage_in(receiver_coil_voltage_in));
`default_nettype wire

// ### testbench/sscs_rx_model.sv
// Receiver model taking offered messages promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module sscs_rx_model (
    input wire logic clock_in, // Clock
    input wire logic slow_in, // Random stalls when high
    output logic msg_ready_out // Takes the offered message
);
    integer seed = 80;
    always @(posedge clock_in) begin
        msg_ready_out <= slow_in ? ($random(seed) % 3 == 0) : 1'b1;
    end
endmodule
`default_nettype wire

// ### testbench/sscs_sched_tb_top.sv
// Self-checking bench for the slow-channel scheduler
`timescale 1ns/1ps
`default_nettype none
module sscs_sched_tb_top;
    import sscs_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, slow = 0;
    logic rdy, pready, perr, v, irq, er;
    logic [7:0] pa = 0, id;
    logic [31:0] pwd = 0, prd, rd;
    logic [4:0] s;
    logic [11:0] d, tmp = 12'h5a3, rev, sty, idw, mfr;
    logic [8:0] ff = 9'h1c6;
    logic [16:0] vr = 17'h1b2c4;
    logic [15:0] ur [16];
    logic [15:0] pg;
    logic [7:0] exc;
    integer seed = 80, n_errors = 0, compares = 0, cyc = 0, taken = 0, st = 0, ms = 1;
    sscs_sched i_sscs_sched (.clock_in(clk), .sys_rst_in(rst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(pready), .pslverr_out(perr), .fault_flags_in(ff),
        .temperature_in(tmp), .receiver_coil_voltage_in(vr), .msg_valid_out(v),
        .msg_ready_in(rdy), .msg_slot_out(s), .msg_id_out(id), .msg_data_out(d),
        .irq_out(irq));
    sscs_rx_model i_sscs_rx_model (.clock_in(clk), .slow_in(slow), .msg_ready_out(rdy));
    initial forever #2.5 clk = ~clk;
    function automatic logic [19:0] exp_msg(input int k);
        int n;
        logic [3:0] p;
        n = 0;
        for (int j = 1; j < k; j++) if (j % 4 == 0 || j % 4 == 3 || j == 2) n++;
        p = pg[4 * ((k - 2) / 8) +: 4];
        case (k)
            6: return {8'h03, sty};
            10: return {8'h05, mfr};
            14: return {8'h06, rev};
            18: return {8'h23, tmp};
            22: return {8'h83, 4'h0, exc};
            26: return {8'h85, vr[16:5]};
            30: return {8'h87, idw};
            default: return k % 4 == 1 ? {8'h01, 3'h0, ff} : {p, ur[n]};
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reference model of the schedule, checked at every take
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
        if (v === 1'b1 && rdy === 1'b1) begin
            chk({7'h0, s, id, d}, {7'h0, ms[4:0], exp_msg(ms)});
            if (ms % 4 == 1 && ff != 0) st = st | 2;
            if (ms == 31) st = st | 1;
            ms = (ms == 31) ? 1 : ms + 1;
            taken++;
            ff <= 9'($random(seed));
            tmp <= 12'($random(seed));
            vr <= 17'($random(seed));
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) ur[i] = 16'($random(seed));
        pg = 16'($random(seed));
        {rev, sty, idw} = 36'({$random(seed), $random(seed)});
        {mfr, exc} = 20'($random(seed));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(SSCS_ADDR_PAGES, 32'h4321);
        rdchk(SSCS_ADDR_SLOT, 32'h1);
        rdchk(8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int i = 0; i < 16; i++) apb(1'b1, SSCS_ADDR_USER + 8'(4 * i), {16'h0, ur[i]});
        apb(1'b1, SSCS_ADDR_PAGES, {16'h0, pg});
        apb(1'b1, SSCS_ADDR_REV, {20'h0, rev});
        apb(1'b1, SSCS_ADDR_STYPE, {20'h0, sty});
        apb(1'b1, SSCS_ADDR_IDENT, {20'h0, idw});
        apb(1'b1, SSCS_ADDR_MFR, {20'h0, mfr});
        apb(1'b1, SSCS_ADDR_EXC, {24'h0, exc});
        apb(1'b1, SSCS_ADDR_CTRL, 32'h1);
        wait (taken >= 31);
        slow <= 1'b1;
        wait (taken >= 62);
        slow <= 1'b0;
        apb(1'b1, SSCS_ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(SSCS_ADDR_SLOT, 32'(ms));
        apb(1'b1, SSCS_ADDR_MASK, 32'h3);
        @(negedge clk);
        chk({31'h0, irq}, 32'(st != 0));
        rdchk(SSCS_ADDR_STATUS, 32'(st));
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(SSCS_ADDR_STATUS, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
